// ### inc/ssrf_pkg.sv
package ssrf_pkg;

  // ----------------------------------------------------------------
  // receive section operating states, gray coded along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSRF_QUIET   = 2'h0,
    SSRF_ARMED   = 2'h1,
    SSRF_FRAMING = 2'h3,
    SSRF_RUN     = 2'h2
  } ssrf_state_e;

  // ----------------------------------------------------------------
  // programmed channel instruction kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSRF_INS_NONE   = 2'h0,
    SSRF_INS_DATA   = 2'h1,
    SSRF_INS_STATUS = 2'h2,
    SSRF_INS_CMD    = 2'h3
  } ssrf_ins_e;

  // ----------------------------------------------------------------
  // channel request and answer carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    ssrf_ins_e   kind;
    logic [7:0]  addr;
    logic [15:0] data;
  } ssrf_req_s;

  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } ssrf_resp_s;

  // ----------------------------------------------------------------
  // widths, codes and field positions
  // ----------------------------------------------------------------
  localparam int SSRF_BYTE_W = 8;
  localparam logic [2:0] SSRF_LAST_BIT = 3'h7;
  localparam logic [7:0] SSRF_SYNC_DEF = 8'h16;
  // controller base address, arbitrary; the receive section uses lsb one
  localparam logic [6:0] SSRF_BASE_DEF = 7'h10;
  localparam logic SSRF_RX_ADDR_LSB = 1'b1;
  // command code in the low nibble of the accumulator
  localparam logic [3:0] SSRF_CMD_RECSEP = 4'h1;
  localparam logic [3:0] SSRF_CMD_INHIBIT = 4'h4;
  localparam logic [3:0] SSRF_CMD_ALLOW = 4'h8;
  // bus bit k carries line A(15-k); parity sits on line A10
  localparam int SSRF_PAR_BIT = 5;
  localparam logic SSRF_ALLOW_RST = 1'b0;

endpackage

// ### rtl/ssrf_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ssrf_sync
  import ssrf_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // crossing data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        q_reg[i] <= 1'b0;
      end else if (s2_reg[i] == s3_reg[i]) begin
        q_reg[i] <= s3_reg[i];
      end
    end
  end

  assign q_o = q_reg;

endmodule

`default_nettype wire

// ### rtl/ssrf_receiver.sv
`timescale 1ns/1ps
`default_nettype none

module ssrf_receiver
  import ssrf_pkg::*;
#(
  parameter logic [7:0] SYNC_CHAR = SSRF_SYNC_DEF,
  parameter logic [6:0] BASE_ADDR = SSRF_BASE_DEF
) (
  // system clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // host side
  input wire logic io_reset_i,
  input wire ssrf_req_s req_i,
  output ssrf_resp_s resp_o,
  output logic srq_o,
  // status view
  output ssrf_state_e state_o,
  output logic timing_err_o,
  // modem receiver
  input wire logic rx_clk_i,
  input wire logic rx_data_i,
  input wire logic carrier_i
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ssrf_state_e lstate_reg;
  logic [7:0] lsh_reg;
  logic [7:0] lsh_next;
  logic [2:0] lcnt_reg;
  logic lfound_reg;
  logic lprev_reg;
  logic [7:0] lhold_reg;
  logic lhold_par_reg;
  logic lbyte_tgl_reg;
  logic [2:0] lin_q;
  logic lcar;
  logic lrs_tgl;
  logic lio_tgl;
  logic lrs_last_reg;
  logic lio_last_reg;
  logic lrs_ev;
  logic lio_ev;
  logic ldeliver;

  logic srs_tgl_reg;
  logic sio_tgl_reg;
  logic [3:0] sin_q;
  logic sbyte_tgl;
  logic scar;
  ssrf_state_e sstate;
  logic sbyte_last_reg;
  logic sbyte_ev;
  logic [7:0] sdata_reg;
  logic spar_reg;
  logic spend_reg;
  logic sterr_reg;
  logic sallow_reg;
  logic hit;
  logic do_data;
  logic do_status;
  logic do_cmd;
  logic [3:0] cmd_code;
  logic data_read;
  ssrf_resp_s resp_reg;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  // into the link domain: carrier pin and host command toggles
  ssrf_sync #(
    .W(3)
  ) u_sync_link (
    .clk_i(rx_clk_i),
    .resetn_i(resetn_i),
    .d_i({carrier_i, srs_tgl_reg, sio_tgl_reg}),
    .q_o(lin_q)
  );

  assign lcar = lin_q[2];
  assign lrs_tgl = lin_q[1];
  assign lio_tgl = lin_q[0];

  // into the system domain: byte toggle, carrier and gray state
  ssrf_sync #(
    .W(4)
  ) u_sync_sys (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({lbyte_tgl_reg, carrier_i, lstate_reg}),
    .q_o(sin_q)
  );

  assign sbyte_tgl = sin_q[3];
  assign scar = sin_q[2];

  // ----------------------------------------------------------------
  // link domain: command edges
  // ----------------------------------------------------------------
  always_ff @(posedge rx_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lrs_last_reg <= 1'b0;
      lio_last_reg <= 1'b0;
    end else begin
      lrs_last_reg <= lrs_tgl;
      lio_last_reg <= lio_tgl;
    end
  end

  assign lrs_ev = lrs_tgl ^ lrs_last_reg;
  assign lio_ev = lio_tgl ^ lio_last_reg;

  // ----------------------------------------------------------------
  // link domain: serial shift
  // ----------------------------------------------------------------
  // first received bit ends in bit 0, which is line A15
  assign lsh_next = {rx_data_i, lsh_reg[7:1]};

  always_ff @(posedge rx_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lsh_reg <= 8'h00;
      lprev_reg <= 1'b1;
    end else begin
      lsh_reg <= lsh_next;
      lprev_reg <= rx_data_i;
    end
  end

  // ----------------------------------------------------------------
  // link domain: framing state machine
  // ----------------------------------------------------------------
  always_ff @(posedge rx_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lstate_reg <= SSRF_QUIET;
      lcnt_reg <= 3'h0;
      lfound_reg <= 1'b0;
    end else if (lio_ev || !lcar) begin
      lstate_reg <= SSRF_QUIET;
      lcnt_reg <= 3'h0;
      lfound_reg <= 1'b0;
    end else if (lrs_ev) begin
      lstate_reg <= SSRF_ARMED;
      lcnt_reg <= 3'h0;
      lfound_reg <= 1'b0;
    end else begin
      case (lstate_reg)
        SSRF_QUIET: begin
          lstate_reg <= SSRF_ARMED;
        end
        SSRF_ARMED: begin
          if (lprev_reg && !rx_data_i) begin
            lstate_reg <= SSRF_FRAMING;
            lfound_reg <= 1'b0;
          end
          lcnt_reg <= 3'h0;
        end
        SSRF_FRAMING: begin
          if (!lfound_reg) begin
            // sliding hunt, one compare per bit
            if (lsh_next == SYNC_CHAR) begin
              lfound_reg <= 1'b1;
            end
            lcnt_reg <= 3'h0;
          end else begin
            lcnt_reg <= lcnt_reg + 3'h1;
            if (lcnt_reg == SSRF_LAST_BIT) begin
              lfound_reg <= 1'b0;
              if (lsh_next == SYNC_CHAR) begin
                lstate_reg <= SSRF_RUN;
              end else begin
                lstate_reg <= SSRF_ARMED;
              end
            end
          end
        end
        SSRF_RUN: begin
          lcnt_reg <= lcnt_reg + 3'h1;
        end
        default: begin
          lstate_reg <= SSRF_QUIET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link domain: byte hand-off
  // ----------------------------------------------------------------
  // the second sync and every run byte go to the host
  assign ldeliver = lcar && !lio_ev && !lrs_ev && (lcnt_reg == SSRF_LAST_BIT) &&
                    ((lstate_reg == SSRF_RUN) ||
                     ((lstate_reg == SSRF_FRAMING) && lfound_reg &&
                      (lsh_next == SYNC_CHAR)));

  // hold stays stable for a full byte time, so the host side
  // may sample it after the toggle has crossed
  always_ff @(posedge rx_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lhold_reg <= 8'h00;
      lhold_par_reg <= 1'b0;
      lbyte_tgl_reg <= 1'b0;
    end else if (ldeliver) begin
      lhold_reg <= lsh_next;
      lhold_par_reg <= ~^lsh_next;
      lbyte_tgl_reg <= ~lbyte_tgl_reg;
    end
  end

  // ----------------------------------------------------------------
  // system domain: instruction decode
  // ----------------------------------------------------------------
  assign hit = req_i.valid && (req_i.addr[7:1] == BASE_ADDR) &&
               (req_i.addr[0] == SSRF_RX_ADDR_LSB);
  assign do_data = hit && (req_i.kind == SSRF_INS_DATA);
  assign do_status = hit && (req_i.kind == SSRF_INS_STATUS);
  assign do_cmd = hit && (req_i.kind == SSRF_INS_CMD);
  assign cmd_code = req_i.data[3:0];
  assign data_read = do_data && spend_reg;

  // ----------------------------------------------------------------
  // system domain: command toggles toward the link
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      srs_tgl_reg <= 1'b0;
      sio_tgl_reg <= 1'b0;
    end else begin
      if (do_cmd && (cmd_code == SSRF_CMD_RECSEP)) begin
        srs_tgl_reg <= ~srs_tgl_reg;
      end
      if (io_reset_i) begin
        sio_tgl_reg <= ~sio_tgl_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain: received byte and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sbyte_last_reg <= 1'b0;
    end else begin
      sbyte_last_reg <= sbyte_tgl;
    end
  end

  assign sbyte_ev = sbyte_tgl ^ sbyte_last_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sdata_reg <= 8'h00;
      spar_reg <= 1'b0;
    end else if (sbyte_ev) begin
      sdata_reg <= lhold_reg;
      spar_reg <= lhold_par_reg;
    end
  end

  // new byte wins over a read in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      spend_reg <= 1'b0;
    end else if (sbyte_ev) begin
      spend_reg <= 1'b1;
    end else if (data_read || io_reset_i) begin
      spend_reg <= 1'b0;
    end
  end

  // only an unread byte counts; status reads play no part
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sterr_reg <= 1'b0;
    end else if (sbyte_ev && spend_reg && !data_read) begin
      sterr_reg <= 1'b1;
    end else if (do_cmd || io_reset_i) begin
      sterr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sallow_reg <= SSRF_ALLOW_RST;
    end else if (io_reset_i) begin
      sallow_reg <= SSRF_ALLOW_RST;
    end else if (do_cmd && (cmd_code == SSRF_CMD_INHIBIT)) begin
      sallow_reg <= 1'b0;
    end else if (do_cmd && (cmd_code == SSRF_CMD_ALLOW)) begin
      sallow_reg <= 1'b1;
    end
  end

  // request follows the kept status and the allow gate
  assign srq_o = sallow_reg && (spend_reg || sterr_reg);

  // ----------------------------------------------------------------
  // system domain: answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resp_reg <= '0;
    end else begin
      resp_reg <= '0;
      if (data_read) begin
        resp_reg.ack <= 1'b1;
        resp_reg.data <= {8'h00, sdata_reg};
      end else if (do_status) begin
        resp_reg.ack <= 1'b1;
        resp_reg.data[SSRF_PAR_BIT] <= spar_reg;
      end else if (do_cmd) begin
        resp_reg.ack <= 1'b1;
      end
    end
  end

  assign resp_o = resp_reg;

  // ----------------------------------------------------------------
  // status view
  // ----------------------------------------------------------------
  // carrier loss shows four system clocks later, through the system-side sync, even if the receive clock has stopped
  assign sstate = scar ? ssrf_state_e'(sin_q[1:0]) : SSRF_QUIET;
  assign state_o = sstate;
  assign timing_err_o = sterr_reg;

endmodule

`default_nettype wire

// ### tb/ssrf_receiver_props.sv
`timescale 1ns/1ps
`default_nettype none

module ssrf_receiver_props
  import ssrf_pkg::*;
#(
  parameter logic [6:0] BASE_ADDR = SSRF_BASE_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // watched ports
  input wire logic io_reset_i,
  input wire ssrf_req_s req_i,
  input wire ssrf_resp_s resp_o,
  input wire logic srq_o,
  input wire ssrf_state_e state_o,
  input wire logic timing_err_o,
  input wire logic carrier_i
);
  logic take_rx;
  logic take_data;
  logic take_status;
  logic take_cmd;
  assign take_rx = req_i.valid && (req_i.addr == {BASE_ADDR, SSRF_RX_ADDR_LSB});
  assign take_data = take_rx && (req_i.kind == SSRF_INS_DATA);
  assign take_status = take_rx && (req_i.kind == SSRF_INS_STATUS);
  assign take_cmd = take_rx && (req_i.kind == SSRF_INS_CMD);

  // ----------------------------------------------------------------
  // channel and state checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_take_data; take_data && srq_o && !timing_err_o; endsequence
  sequence s_take_status; take_status; endsequence
  sequence s_take_cmd; take_cmd; endsequence
  sequence s_carrier_gone; !carrier_i [*6]; endsequence

  property p_status_fmt; s_take_status |=> resp_o.ack && ((resp_o.data & ~(16'h1 << SSRF_PAR_BIT)) == 16'h0);
  endproperty
  a_status_fmt: assert property (p_status_fmt) else $error("status answer malformed");
  property p_other_addr; req_i.valid && (req_i.addr[0] != SSRF_RX_ADDR_LSB) |=> !resp_o.ack; endproperty
  a_other_addr: assert property (p_other_addr) else $error("ack for other section");
  property p_high_zero; resp_o.ack |-> resp_o.data[15:8] == 8'h00; endproperty
  a_high_zero: assert property (p_high_zero) else $error("high byte not zero");
  property p_read_clears; s_take_data |=> resp_o.ack && !srq_o; endproperty
  a_read_clears: assert property (p_read_clears) else $error("data read kept request");
  property p_cmd_ack; s_take_cmd |=> resp_o.ack; endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("command not acked");
  property p_inhibit; s_take_cmd ##0 (req_i.data[3:0] == SSRF_CMD_INHIBIT) |=> !srq_o; endproperty
  a_inhibit: assert property (p_inhibit) else $error("request after inhibit");
  property p_io_reset; io_reset_i |=> !srq_o && !timing_err_o; endproperty
  a_io_reset: assert property (p_io_reset) else $error("io reset left request");
  property p_carrier; s_carrier_gone |-> state_o == SSRF_QUIET; endproperty
  a_carrier: assert property (p_carrier) else $error("not quiescent without carrier");
  property p_err_sticky; timing_err_o && !take_cmd && !io_reset_i |=> timing_err_o; endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("timing error lost");
  property p_run_entry; (state_o == SSRF_RUN) && ($past(state_o) != SSRF_RUN) |-> $past(state_o) == SSRF_FRAMING;
  endproperty
  a_run_entry: assert property (p_run_entry) else $error("run entered not from framing");
endmodule

bind ssrf_receiver ssrf_receiver_props #(.BASE_ADDR(BASE_ADDR)) props_u (.clk_i(clk_i), .resetn_i(resetn_i),
  .io_reset_i(io_reset_i), .req_i(req_i), .resp_o(resp_o), .srq_o(srq_o), .state_o(state_o),
  .timing_err_o(timing_err_o), .carrier_i(carrier_i));

`default_nettype wire

// ### tb/ssrf_modem_model.sv
`timescale 1ns/1ps
`default_nettype none

module ssrf_modem_model (
  // modem receiver side
  output logic rx_clk_o,
  output logic rx_data_o,
  output logic carrier_o
);
  initial begin
    rx_clk_o = 1'b0;
    rx_data_o = 1'b1;
    carrier_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // bit clocking, one clock pulse per bit sent or marked, clock stands still between calls
  // ----------------------------------------------------------------
  task automatic bit_out(input logic b);
    rx_data_o = b;
    #32 rx_clk_o = 1'b1;
    #32 rx_clk_o = 1'b0;
  endtask

  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      bit_out(b[i]);
    end
  endtask

  task automatic mark(input int n);
    #7.3;
    repeat (n) bit_out(1'b1);
  endtask

  // line no longer held once the clock stops
  task automatic release_line();
    rx_data_o = ~rx_data_o;
  endtask

  task automatic set_carrier(input logic on);
    carrier_o = on;
  endtask
endmodule

`default_nettype wire

// ### tb/sync_serial_receive_framer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sync_serial_receive_framer_tb
  import ssrf_pkg::*;
;
  localparam logic [7:0] RX_A = {SSRF_BASE_DEF, SSRF_RX_ADDR_LSB};
  logic clk_i;
  logic resetn_i;
  logic io_reset_i;
  ssrf_req_s req_i;
  ssrf_resp_s resp_o;
  ssrf_resp_s r;
  logic srq_o;
  ssrf_state_e state_o;
  logic timing_err_o;
  wire rx_clk_i;
  wire rx_data_i;
  wire carrier_i;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 27115;
  logic [7:0] tx [0:8];
  logic [7:0] ra;

  always #12.5 clk_i = ~clk_i;

  ssrf_receiver dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .io_reset_i(io_reset_i), .req_i(req_i),
    .resp_o(resp_o), .srq_o(srq_o), .state_o(state_o), .timing_err_o(timing_err_o),
    .rx_clk_i(rx_clk_i), .rx_data_i(rx_data_i), .carrier_i(carrier_i));
  ssrf_modem_model m_u (.rx_clk_o(rx_clk_i), .rx_data_o(rx_data_i), .carrier_o(carrier_i));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] par_word(input logic [7:0] b);
    return (~^b) ? (16'h1 << SSRF_PAR_BIT) : 16'h0;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chan(input ssrf_ins_e k, input logic [7:0] a, input logic [15:0] d, output ssrf_resp_s q);
    @(posedge clk_i);
    #2 req_i = '{valid: 1'b1, kind: k, addr: a, data: d};
    @(posedge clk_i);
    #2 q = resp_o;
    req_i = '0;
  endtask

  task automatic wait_srq();
    int n;
    n = 0;
    while (srq_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      #2 n++;
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    resetn_i = 1'b0;
    io_reset_i = 1'b0;
    req_i = '0;
    fork
      m_u.mark(4);
      repeat (10) @(posedge clk_i);
    join
    #2 resetn_i = 1'b1;
    tx[0] = SSRF_SYNC_DEF;
    tx[1] = 8'hff;
    tx[2] = 8'h00;
    for (int i = 3; i < 9; i++) tx[i] = 8'($random(seed));
    chan(SSRF_INS_CMD, RX_A, 16'h0008, r);
    check("allow ack", {15'h0, r.ack}, 16'h0001);
    chan(SSRF_INS_STATUS, RX_A ^ 8'h01, 16'h0000, r);
    check("other section ack", {15'h0, r.ack}, 16'h0000);
    // random requests to even addresses, any base, any kind, any data
    for (int i = 0; i < 4; i++) begin
      ra = {7'($random(seed)), ~SSRF_RX_ADDR_LSB};
      chan(ssrf_ins_e'(2'($random(seed))), ra, 16'($random(seed)), r);
      check("even address ack", {15'h0, r.ack}, 16'h0000);
    end
    fork
      begin
        m_u.set_carrier(1'b1);
        m_u.mark(8);
        m_u.bit_out(1'b0);
        m_u.send(SSRF_SYNC_DEF);
        for (int i = 0; i < 9; i++) m_u.send(tx[i]);
        m_u.release_line();
      end
      for (int i = 0; i < 9; i++) begin
        wait_srq();
        check("srq_o", {15'h0, srq_o}, 16'h0001);
        if (i == 0) check("state", {14'h0, state_o}, {14'h0, SSRF_RUN});
        chan(SSRF_INS_DATA, RX_A, 16'h0000, r);
        check("rx byte", r.data, {8'h00, tx[i]});
        if (i % 2 == 1) begin
          chan(SSRF_INS_STATUS, RX_A, 16'h0000, r);
          check("parity", r.data, par_word(tx[i]));
        end
      end
    join
    check("no status error", {15'h0, timing_err_o}, 16'h0000);
    chan(SSRF_INS_DATA, RX_A, 16'h0000, r);
    check("empty read ack", {15'h0, r.ack}, 16'h0000);
    check("empty read data", r.data, 16'h0000);
    m_u.send(8'h5a);
    m_u.send(8'ha3);
    m_u.mark(1);
    repeat (10) @(posedge clk_i);
    #2 check("late read error", {15'h0, timing_err_o}, 16'h0001);
    chan(SSRF_INS_CMD, RX_A, 16'h0004, r);
    check("inhibit srq", {15'h0, srq_o}, 16'h0000);
    chan(SSRF_INS_CMD, RX_A, 16'h0008, r);
    check("allow srq", {15'h0, srq_o}, 16'h0001);
    chan(SSRF_INS_DATA, RX_A, 16'h0000, r);
    check("newest byte", r.data, 16'h00a3);
    check("run held", {14'h0, state_o}, {14'h0, SSRF_RUN});
    chan(SSRF_INS_CMD, RX_A, 16'h0001, r);
    m_u.mark(8);
    repeat (8) @(posedge clk_i);
    #2 check("separator state", {14'h0, state_o}, {14'h0, SSRF_ARMED});
    m_u.bit_out(1'b0);
    m_u.send(SSRF_SYNC_DEF);
    m_u.send(SSRF_SYNC_DEF ^ 8'h01);
    m_u.mark(8);
    repeat (8) @(posedge clk_i);
    #2 check("failed frame state", {14'h0, state_o}, {14'h0, SSRF_ARMED});
    check("failed frame srq", {15'h0, srq_o}, 16'h0000);
    m_u.set_carrier(1'b0);
    m_u.mark(6);
    m_u.release_line();
    repeat (8) @(posedge clk_i);
    #2 check("carrier off state", {14'h0, state_o}, {14'h0, SSRF_QUIET});
    io_reset_i = 1'b1;
    @(posedge clk_i);
    #2 io_reset_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #2 check("io reset srq", {15'h0, srq_o}, 16'h0000);
    conclude();
  end
endmodule

`default_nettype wire
